// ==== aps_pkg.sv ====
// Package with constants, types and the routing table of the pin selection block
//
// Summary of operation
// - On the 14-pin part bit 7 puts the receive/data function on RC5 when 0 and RA1 when 1; on the 20-pin part 0 selects RB5.
// - On the 14-pin part bit 6 puts the serial data output on RC2 when 0 and RA4 when 1; on the 20-pin part the bit reads 0 and the output stays on RC7.
// - On the 14-pin part bit 5 puts the slave select input on RC3 when 0 and RA3 when 1; on the 20-pin part the bit reads 0 and the pin is fixed.
// - On both parts bit 3 takes the timer gate input from RA4 when 0 and from RA3 when 1.
// - Bit 2 puts transmit/clock on RC4 or RA0 on the 14-pin part, and on RB7 or RC4 on the 20-pin part.
// - Bits 4, 1 and 0 of the selection register ignore writes and read as 0.
// - Every implemented selection bit is read/write and clears to 0 on every reset.
package aps_pkg;

  localparam int          DATA_W    = 32;
  localparam int          NUM_PINS  = 24;
  localparam int          PIN_IDX_W = 5;
  localparam int          NUM_FN    = 5;
  localparam int          SEL_W     = 8;

  // Register byte offsets
  localparam logic [31:0] OFS_PIN_SELECT = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS     = 32'h0000_0004;

  // Selection register layout
  localparam int          BIT_RX    = 7;
  localparam int          BIT_SDO   = 6;
  localparam int          BIT_SS    = 5;
  localparam int          BIT_GATE  = 3;
  localparam int          BIT_TX    = 2;
  localparam logic [7:0]  SEL_RESET   = 8'h00;
  localparam logic [7:0]  SEL_MASK_14 = 8'hEC;
  localparam logic [7:0]  SEL_MASK_20 = 8'h8C;
  localparam logic [7:0]  UNIMPL_MASK = 8'h13;
  localparam int          STAT_VARIANT_BIT = 8;

  // Pin index: port A 0..7, port B 8..15, port C 16..23
  localparam logic [4:0]  PIN_RA0 = 5'h00;
  localparam logic [4:0]  PIN_RA1 = 5'h01;
  localparam logic [4:0]  PIN_RA3 = 5'h03;
  localparam logic [4:0]  PIN_RA4 = 5'h04;
  localparam logic [4:0]  PIN_RB5 = 5'h0D;
  localparam logic [4:0]  PIN_RB7 = 5'h0F;
  localparam logic [4:0]  PIN_RC2 = 5'h12;
  localparam logic [4:0]  PIN_RC3 = 5'h13;
  localparam logic [4:0]  PIN_RC4 = 5'h14;
  localparam logic [4:0]  PIN_RC5 = 5'h15;
  localparam logic [4:0]  PIN_RC6 = 5'h16;
  localparam logic [4:0]  PIN_RC7 = 5'h17;
  localparam logic [4:0]  PIN_RX_ALT_20   = PIN_RC5;
  localparam logic [4:0]  PIN_SS_FIXED_20 = PIN_RC6;

  // Function slots, lower slot wins a shared pin
  localparam int          FN_RX   = 0;
  localparam int          FN_SDO  = 1;
  localparam int          FN_SS   = 2;
  localparam int          FN_GATE = 3;
  localparam int          FN_TX   = 4;

  // Bus encodings
  localparam logic [1:0]  HTRANS_IDLE = 2'h0;
  localparam logic        HRESP_OKAY  = 1'h0;

  typedef logic [NUM_PINS-1:0]  aps_pins_t;
  typedef logic [PIN_IDX_W-1:0] aps_pin_idx_t;
  typedef logic [SEL_W-1:0]     aps_sel_t;

  typedef struct packed {
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic              hready;
    logic [DATA_W-1:0] hwdata;
  } aps_ahb_req_s;

  typedef struct packed {
    logic serial_receive_data_fn_o;
    logic serial_receive_data_fn_oe;
    logic serial_transmit_clock_fn_o;
    logic serial_transmit_clock_fn_oe;
    logic sdo_o;
    logic sdo_oe;
  } aps_fn_out_s;

  typedef struct packed {
    logic serial_transmit_clock_fn;
    logic gate;
    logic ss_n;
    logic serial_receive_data_fn;
  } aps_fn_in_s;

  function automatic aps_pin_idx_t aps_pin_of(input int fn, input logic pkg20,
                                              input logic sel);
    aps_pin_idx_t idx;
    idx = PIN_RA0;
    case (fn)
      FN_RX:   idx = pkg20 ? (sel ? PIN_RX_ALT_20 : PIN_RB5) : (sel ? PIN_RA1 : PIN_RC5);
      FN_SDO:  idx = pkg20 ? PIN_RC7 : (sel ? PIN_RA4 : PIN_RC2);
      FN_SS:   idx = pkg20 ? PIN_SS_FIXED_20 : (sel ? PIN_RA3 : PIN_RC3);
      FN_GATE: idx = sel ? PIN_RA3 : PIN_RA4;
      FN_TX:   idx = pkg20 ? (sel ? PIN_RC4 : PIN_RB7) : (sel ? PIN_RA0 : PIN_RC4);
      default: idx = PIN_RA0;
    endcase
    return idx;
  endfunction

endpackage

// ==== aps_pin_router.sv ====
// Combinational crossbar between peripheral functions and package pins
`timescale 1ns/1ps
module aps_pin_router #(
  parameter int NUM_FN   = aps_pkg::NUM_FN,
  parameter int NUM_PINS = aps_pkg::NUM_PINS,
  parameter int IDX_W    = aps_pkg::PIN_IDX_W
) (
  // Function side
  input  wire logic [NUM_FN-1:0][IDX_W-1:0] fn_pin,
  input  wire logic [NUM_FN-1:0]            fn_drv_o,
  input  wire logic [NUM_FN-1:0]            fn_drv_oe,
  output logic      [NUM_FN-1:0]            fn_in,
  // Port latch side
  input  wire logic [NUM_PINS-1:0]          gpio_o,
  input  wire logic [NUM_PINS-1:0]          gpio_oe,
  // Pin side
  input  wire logic [NUM_PINS-1:0]          pins_in,
  output logic      [NUM_PINS-1:0]          pins_o,
  output logic      [NUM_PINS-1:0]          pins_oe
);

  genvar p;
  genvar f;

  // A pin not claimed by a driving function falls back to the port latch
  generate
    for (p = 0; p < NUM_PINS; p++)
    begin : g_pin
      logic o_b;
      logic oe_b;
      always_comb
      begin
        o_b  = gpio_o[p];
        oe_b = gpio_oe[p];
        for (int k = NUM_FN - 1; k >= 0; k--)
        begin
          if (fn_drv_oe[k] && (fn_pin[k] == IDX_W'(p)))
          begin
            o_b  = fn_drv_o[k];
            oe_b = 1'b1;
          end
        end
      end
      assign pins_o[p]  = o_b;
      assign pins_oe[p] = oe_b;
    end
  endgenerate

  generate
    for (f = 0; f < NUM_FN; f++)
    begin : g_fn
      assign fn_in[f] = pins_in[fn_pin[f]];
    end
  endgenerate

endmodule // aps_pin_router

// ==== aps_ahb_slave.sv ====
// Zero-wait AHB-Lite slave front end for the register file
`timescale 1ns/1ps
module aps_ahb_slave (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Bus
  input  wire aps_pkg::aps_ahb_req_s req,
  output logic [aps_pkg::DATA_W-1:0] hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Register file side
  output logic [31:0]                rd_addr,
  input  wire logic [aps_pkg::DATA_W-1:0] rd_data,
  output logic                       wr_en,
  output logic [31:0]                wr_addr
);
  import aps_pkg::*;

  logic              wr_pend_q, wr_pend_d;
  logic [31:0]       wr_addr_q, wr_addr_d;
  logic [DATA_W-1:0] hrdata_q, hrdata_d;
  logic              hready_q;
  logic              addr_ok;

  // Read data is sampled in the address phase, so data phase needs no wait
  assign addr_ok = req.hsel && req.hready && (req.htrans != HTRANS_IDLE) && req.htrans[1];
  assign rd_addr = req.haddr;

  always_comb
  begin
    wr_pend_d = addr_ok && req.hwrite;
    wr_addr_d = addr_ok ? req.haddr : wr_addr_q;
    hrdata_d  = (addr_ok && !req.hwrite) ? rd_data : hrdata_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      hrdata_q  <= 32'h0000_0000;
      hready_q  <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q  <= hrdata_d;
      hready_q  <= 1'b1;
    end
  end

  assign wr_en     = wr_pend_q;
  assign wr_addr   = wr_addr_q;
  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = HRESP_OKAY;

endmodule // aps_ahb_slave

// ==== aps_pin_select.sv ====
// Top of the alternate pin selection block: register, routing and pin registers
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module aps_pin_select #(
  parameter bit PKG20 = 1'b0
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // AHB-Lite slave
  input  wire aps_pkg::aps_ahb_req_s ahb_req,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Peripheral functions
  input  wire aps_pkg::aps_fn_out_s  fn_out_i,
  output aps_pkg::aps_fn_in_s        fn_in_o,
  // Port latches
  input  wire aps_pkg::aps_pins_t    gpio_o_i,
  input  wire aps_pkg::aps_pins_t    gpio_oe_i,
  // Package pins
  input  wire aps_pkg::aps_pins_t    pins_i,
  output aps_pkg::aps_pins_t         pins_o,
  output aps_pkg::aps_pins_t         pins_oe
);
  import aps_pkg::*;

  localparam aps_sel_t WR_MASK = PKG20 ? SEL_MASK_20 : SEL_MASK_14;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus front end

  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic        wr_en;
  logic [31:0] wr_addr;

  aps_ahb_slave u_bus (
    .clk       (clk),
    .rst_n     (rst_n),
    .req       (ahb_req),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Selection register

  aps_sel_t sel_q, sel_d;
  logic     sel_wr;

  assign sel_wr = wr_en && (wr_addr == OFS_PIN_SELECT);

  always_comb
  begin
    sel_d = sel_q;
    if (sel_wr)
      sel_d = ahb_req.hwdata[SEL_W-1:0] & WR_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sel_q <= SEL_RESET;
    else
      sel_q <= sel_d;
  end

  // Forwarding sel_d lets a read right behind a write see the new value
  aps_fn_in_s fn_in_q, fn_in_d;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (rd_addr == OFS_PIN_SELECT)
      rd_data[SEL_W-1:0] = sel_d;
    else if (rd_addr == OFS_STATUS)
    begin
      rd_data[3:0]              = fn_in_q;
      rd_data[STAT_VARIANT_BIT] = PKG20;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser

  aps_pins_t pins_meta_q;
  aps_pins_t pins_sync_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins_meta_q <= '0;
      pins_sync_q <= '0;
    end
    else
    begin
      pins_meta_q <= pins_i;
      pins_sync_q <= pins_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Routing

  // The next selection steers the router so pins change on the same edge as the register
  logic [NUM_FN-1:0][PIN_IDX_W-1:0] fn_pin;
  logic [NUM_FN-1:0]                fn_drv_o;
  logic [NUM_FN-1:0]                fn_drv_oe;
  logic [NUM_FN-1:0]                fn_in_raw;
  aps_pins_t                        pins_o_d;
  aps_pins_t                        pins_oe_d;

  always_comb
  begin
    fn_pin[FN_RX]   = aps_pin_of(FN_RX,   PKG20, sel_d[BIT_RX]);
    fn_pin[FN_SDO]  = aps_pin_of(FN_SDO,  PKG20, sel_d[BIT_SDO]);
    fn_pin[FN_SS]   = aps_pin_of(FN_SS,   PKG20, sel_d[BIT_SS]);
    fn_pin[FN_GATE] = aps_pin_of(FN_GATE, PKG20, sel_d[BIT_GATE]);
    fn_pin[FN_TX]   = aps_pin_of(FN_TX,   PKG20, sel_d[BIT_TX]);
    fn_drv_o            = '0;
    fn_drv_oe           = '0;
    fn_drv_o[FN_RX]     = fn_out_i.serial_receive_data_fn_o;
    fn_drv_oe[FN_RX]    = fn_out_i.serial_receive_data_fn_oe;
    fn_drv_o[FN_SDO]    = fn_out_i.sdo_o;
    fn_drv_oe[FN_SDO]   = fn_out_i.sdo_oe;
    fn_drv_o[FN_TX]     = fn_out_i.serial_transmit_clock_fn_o;
    fn_drv_oe[FN_TX]    = fn_out_i.serial_transmit_clock_fn_oe;
  end

  aps_pin_router u_router (
    .fn_pin    (fn_pin),
    .fn_drv_o  (fn_drv_o),
    .fn_drv_oe (fn_drv_oe),
    .fn_in     (fn_in_raw),
    .gpio_o    (gpio_o_i),
    .gpio_oe   (gpio_oe_i),
    .pins_in   (pins_sync_q),
    .pins_o    (pins_o_d),
    .pins_oe   (pins_oe_d)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers

  aps_pins_t pins_o_q;
  aps_pins_t pins_oe_q;

  always_comb
  begin
    fn_in_d.serial_receive_data_fn = fn_in_raw[FN_RX];
    fn_in_d.ss_n  = fn_in_raw[FN_SS];
    fn_in_d.gate  = fn_in_raw[FN_GATE];
    fn_in_d.serial_transmit_clock_fn = fn_in_raw[FN_TX];
  end

  // Pins come out of reset released so nothing fights the board
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins_o_q  <= '0;
      pins_oe_q <= '0;
      fn_in_q   <= '0;
    end
    else
    begin
      pins_o_q  <= pins_o_d;
      pins_oe_q <= pins_oe_d;
      fn_in_q   <= fn_in_d;
    end
  end

  assign pins_o  = pins_o_q;
  assign pins_oe = pins_oe_q;
  assign fn_in_o = fn_in_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  aps_pin_idx_t rx_exp, sdo_exp, ss_exp, gate_exp, tx_exp, tx_old;

  // One-cycle-old copies so that the checks can pick a pin with the current selection.
  // Indexing inside $past would pick the pin with the old selection instead.
  aps_pins_t    pins_sync_p;
  aps_pins_t    gpio_o_p;
  aps_pins_t    gpio_oe_p;

  always_ff @(posedge clk)
  begin
    pins_sync_p <= pins_sync_q;
    gpio_o_p    <= gpio_o_i;
    gpio_oe_p   <= gpio_oe_i;
  end

  always_comb
  begin
    rx_exp   = PKG20 ? (sel_q[BIT_RX] ? PIN_RX_ALT_20 : PIN_RB5)
                     : (sel_q[BIT_RX] ? PIN_RA1 : PIN_RC5);
    sdo_exp  = PKG20 ? PIN_RC7 : (sel_q[BIT_SDO] ? PIN_RA4 : PIN_RC2);
    ss_exp   = PKG20 ? PIN_SS_FIXED_20 : (sel_q[BIT_SS] ? PIN_RA3 : PIN_RC3);
    gate_exp = sel_q[BIT_GATE] ? PIN_RA3 : PIN_RA4;
    tx_exp   = PKG20 ? (sel_q[BIT_TX] ? PIN_RC4 : PIN_RB7)
                     : (sel_q[BIT_TX] ? PIN_RA0 : PIN_RC4);
    tx_old   = PKG20 ? (sel_q[BIT_TX] ? PIN_RB7 : PIN_RC4)
                     : (sel_q[BIT_TX] ? PIN_RC4 : PIN_RA0);
  end

  sequence s_sel_write;
    sel_wr;
  endsequence

  sequence s_tx_moved;
    s_sel_write ##1 $changed(sel_q[BIT_TX]);
  endsequence

  a_rx_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $past(fn_out_i.serial_receive_data_fn_oe))
      |-> (pins_oe_q[rx_exp] && (pins_o_q[rx_exp] == $past(fn_out_i.serial_receive_data_fn_o))))
    else $error("receive/data output not on its selected pin");

  a_sdo_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $past(fn_out_i.sdo_oe))
      |-> (pins_oe_q[sdo_exp] && (pins_o_q[sdo_exp] == $past(fn_out_i.sdo_o))
           && !(PKG20 && sel_q[BIT_SDO])))
    else $error("serial data output not on its selected pin");

  a_ss_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> (fn_in_q.ss_n == pins_sync_p[ss_exp]))
    else $error("slave select taken from the wrong pin");

  a_gate_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> (fn_in_q.gate == pins_sync_p[gate_exp]))
    else $error("timer gate taken from the wrong pin");

  a_tx_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> ((fn_in_q.serial_transmit_clock_fn == pins_sync_p[tx_exp])
                      && (!$past(fn_out_i.serial_transmit_clock_fn_oe) || pins_oe_q[tx_exp])))
    else $error("transmit/clock not on its selected pin");

  a_unimpl_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_sel_write |=> (((sel_q & UNIMPL_MASK) == '0) && ((sel_q & ~WR_MASK) == '0)))
    else $error("unimplemented selection bit took a write");

  a_sel_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_sel_write |=> (sel_q == ($past(ahb_req.hwdata[SEL_W-1:0]) & WR_MASK)))
    else $error("selection register did not take the written value");

  a_sel_reset: assert property (
    @(posedge clk)
    !rst_n |=> ((sel_q == SEL_RESET) && (pins_oe_q == '0)))
    else $error("selection register not cleared by reset");

  a_pin_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_tx_moved |-> ((pins_oe_q[tx_old] == gpio_oe_p[tx_old])
                    && (pins_o_q[tx_old] == gpio_o_p[tx_old])))
    else $error("pin given up by transmit/clock did not return to port use");

endmodule // aps_pin_select

// ==== aps_far_side.sv ====
// Model of the peripherals and package pins facing the pin selection block
`timescale 1ns/1ps
module aps_far_side (
  // Bench controls
  input  wire aps_pkg::aps_pins_t  ext_lvl,
  input  wire logic                fn_en,
  input  wire logic                fn_val,
  // Block pins
  input  wire aps_pkg::aps_pins_t  pins_o,
  input  wire aps_pkg::aps_pins_t  pins_oe,
  output aps_pkg::aps_pins_t       pins_i,
  // Peripheral drive
  output aps_pkg::aps_fn_out_s     fn_out
);
  import aps_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // A pin the block drives shows its value, any other the outside level
  assign pins_i = (pins_oe & pins_o) | (~pins_oe & ext_lvl);
  assign fn_out = {fn_val, fn_en, fn_val, fn_en, fn_val, fn_en};
endmodule // aps_far_side

// ==== aps_pin_select_tb.sv ====
// Self-checking testbench of the pin selection block
`timescale 1ns/1ps
module aps_pin_select_tb;
  import aps_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata20;
  aps_fn_out_s  fn_out20;
  aps_fn_in_s   fn_in20;
  aps_pins_t    pins_i20;
  aps_pins_t    pins_o20;
  aps_pins_t    pins_oe20;
  aps_pins_t    dm20;
  aps_ahb_req_s ahb_req;
  aps_fn_out_s  fn_out;
  aps_fn_in_s   fn_in;
  aps_pins_t    gpio_o;
  aps_pins_t    gpio_oe;
  aps_pins_t    pins_i;
  aps_pins_t    pins_o;
  aps_pins_t    pins_oe;
  aps_pins_t    ext_lvl;
  logic         fn_en;
  logic         fn_val;
  int           n_mismatch;
  int           checks;
  int           cyc;
  logic [31:0]  rd;
  aps_pins_t    dm;
  aps_pins_t    im;
  aps_sel_t     sv [7] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'hEC};

  assign ahb_req = {hsel, haddr, htrans, hwrite, 3'h2, hreadyout, hwdata};

  aps_pin_select dut (
    .clk(clk), .rst_n(rst_n), .ahb_req(ahb_req), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fn_out_i(fn_out), .fn_in_o(fn_in),
    .gpio_o_i(gpio_o), .gpio_oe_i(gpio_oe), .pins_i(pins_i), .pins_o(pins_o),
    .pins_oe(pins_oe)
  );

  aps_far_side far (
    .ext_lvl(ext_lvl), .fn_en(fn_en), .fn_val(fn_val), .pins_o(pins_o),
    .pins_oe(pins_oe), .pins_i(pins_i), .fn_out(fn_out)
  );

  // 20-pin variant on the same bus, answering in step with the 14-pin one
  aps_pin_select #(.PKG20(1'b1)) dut20 (
    .clk(clk), .rst_n(rst_n), .ahb_req(ahb_req), .hrdata(hrdata20),
    .hreadyout(), .hresp(), .fn_out_i(fn_out20), .fn_in_o(fn_in20),
    .gpio_o_i(gpio_o), .gpio_oe_i(gpio_oe), .pins_i(pins_i20), .pins_o(pins_o20),
    .pins_oe(pins_oe20)
  );

  aps_far_side far20 (
    .ext_lvl(ext_lvl), .fn_en(fn_en), .fn_val(fn_val), .pins_o(pins_o20),
    .pins_oe(pins_oe20), .pins_i(pins_i20), .fn_out(fn_out20)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; address held until hready seen high
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_in;
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = HTRANS_IDLE;
    hwrite = 1'b0; hwdata = 32'h0; gpio_o = '0; gpio_oe = '0;
    ext_lvl = '0; fn_en = 1'b0; fn_val = 1'b0;
    n_mismatch = 0; checks = 0; cyc = 0;
    do_reset();
    bus(1'b0, OFS_PIN_SELECT, 32'h0, rd);
    chk("sel after reset", 32'h0000_0000, rd);
    bus(1'b1, OFS_PIN_SELECT, 32'hFFFF_FFFF, rd);
    bus(1'b0, OFS_PIN_SELECT, 32'h0, rd);
    chk("sel all ones", 32'h0000_00EC, rd);
    chk("sel20 all ones", 32'h0000_008C, hrdata20);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, 32'h0000_0010, 32'h0000_0000, rd);
    bus(1'b0, 32'h0000_0010, 32'h0, rd);
    chk("unmapped", 32'h0000_0000, rd);
    bus(1'b0, OFS_PIN_SELECT, 32'h0, rd);
    chk("sel kept", 32'h0000_00EC, rd);
    do_reset();
    bus(1'b0, OFS_PIN_SELECT, 32'h0, rd);
    chk("sel after second reset", 32'h0000_0000, rd);
    fn_en  <= 1'b1;
    fn_val <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      dm = (24'h1 << (sv[i][7] ? PIN_RA1 : PIN_RC5)) | (24'h1 << (sv[i][6] ? PIN_RA4 : PIN_RC2))
         | (24'h1 << (sv[i][2] ? PIN_RA0 : PIN_RC4));
      im = (24'h1 << (sv[i][7] ? PIN_RA1 : PIN_RC5)) | (24'h1 << (sv[i][5] ? PIN_RA3 : PIN_RC3))
         | (24'h1 << (sv[i][3] ? PIN_RA3 : PIN_RA4)) | (24'h1 << (sv[i][2] ? PIN_RA0 : PIN_RC4));
      bus(1'b1, OFS_PIN_SELECT, {24'h0, sv[i]}, rd);
      #1;
      chk("pins_oe drive", {8'h0, dm}, {8'h0, pins_oe});
      chk("pins_o drive", {8'h0, dm}, {8'h0, pins_o});
      dm20 = (24'h1 << (sv[i][7] ? PIN_RC5 : PIN_RB5)) | (24'h1 << PIN_RC7)
           | (24'h1 << (sv[i][2] ? PIN_RC4 : PIN_RB7));
      chk("pins_oe20 drive", {8'h0, dm20}, {8'h0, pins_oe20});
      fn_en   <= 1'b0;
      ext_lvl <= im;
      wait_in();
      chk("fn_in high", 32'hF, {28'h0, fn_in});
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status", 32'h0000_000F, rd);
      ext_lvl <= ~im;
      wait_in();
      chk("fn_in low", 32'h0, {28'h0, fn_in});
      fn_en   <= 1'b1;
    end
    // Functions idle: every pin goes back to the port latches
    fn_en   <= 1'b0;
    gpio_oe <= 24'hFFFFFF;
    gpio_o  <= 24'hA5C33C;
    repeat (2) @(posedge clk);
    #1;
    chk("pins_oe port", 32'h00FF_FFFF, {8'h0, pins_oe});
    chk("pins_o port", 32'h00A5_C33C, {8'h0, pins_o});
    report_and_stop();
  end
endmodule // aps_pin_select_tb
